// *** src/lfp_pkg.sv ***
// constants for the link fault propagation block
// assumes a single 25 MHz clock domain with synchronous reset
package lfp_pkg;

  // ==========================================================================
  // media modes
  typedef enum logic [0:0] {
    LFP_MODE_COPPER = 1'h0,
    LFP_MODE_FIBRE  = 1'h1
  } lfp_mode_type;

  // ==========================================================================
  // loopback diagnostic roles
  typedef enum logic [1:0] {
    LFP_LB_OFF     = 2'h0,
    LFP_LB_SINGLE  = 2'h1,
    LFP_LB_CASCADE = 2'h2
  } lfp_loop_type;

  // ==========================================================================
  // transmit selection toward the medium
  typedef enum logic [1:0] {
    LFP_TX_DATA  = 2'h0,
    LFP_TX_FEF   = 2'h1,
    LFP_TX_QUIET = 2'h2,
    LFP_TX_LOOP  = 2'h3
  } lfp_tx_type;

  // reset values of the fault, loop and transmit outputs
  localparam logic LFP_FAULT_RST = 1'h0;
  localparam logic LFP_LOOP_RST  = 1'h0;
  localparam lfp_tx_type LFP_TX_RST = LFP_TX_DATA;

endpackage

// *** src/lfp_core.sv ***
// link fault propagation between the media side and the peer transceiver
// assumes all inputs synchronous to mclk_i; link status comes from the pcs
//
// Function
// - fibre mode separates local receive link loss from far-end remote fault
// - fibre receive link failure raises fibre fault toward peer
// - fibre mode: peer fault makes the fibre transmitter send far-end fault
// - copper mode: receive link failure raises copper fault toward peer
// - copper mode: peer fault stops idle transmission on copper
// - remote auto-loopback of fibre route, single or cascade setup
// - copper and fibre fault are separate outputs beside receive signals
`timescale 1ns/10ps
module lfp_core (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // configuration
  input  wire lfp_pkg::lfp_mode_type mode_i,
  input  wire lfp_pkg::lfp_loop_type loop_mode_i,
  // media status
  input  wire logic                  rx_link_ok_i,
  input  wire logic                  rx_far_end_fault_i,
  // converter_link_interface from the peer
  input  wire logic                  peer_fault_i,
  // converter_link_interface toward the peer
  output logic                       copper_fault_out_o,
  output logic                       fibre_fault_out_o,
  // media transmit control and status
  output lfp_pkg::lfp_tx_type        tx_sel_o,
  output logic                       remote_fault_o,
  output logic                       loop_active_o
);

  // ==========================================================================
  // decoding for the checks; loop_wanted, with fibre_sel, also feeds the next-value logic
  function automatic logic fibre_sel(input lfp_pkg::lfp_mode_type mode);
    return mode == lfp_pkg::LFP_MODE_FIBRE;
  endfunction

  function automatic logic copper_sel(input lfp_pkg::lfp_mode_type mode);
    return mode == lfp_pkg::LFP_MODE_COPPER;
  endfunction

  // loopback only on the fibre route, and only with a live receive link;
  // a dead link would loop nothing back and only hide the local loss
  function automatic logic loop_wanted(input lfp_pkg::lfp_mode_type mode,
                                       input lfp_pkg::lfp_loop_type loop,
                                       input logic                  link_ok);
    return fibre_sel(mode) && (loop != lfp_pkg::LFP_LB_OFF) && link_ok;
  endfunction

  // ==========================================================================
  // state
  logic                copper_fault_out;
  logic                fibre_fault_out;
  lfp_pkg::lfp_tx_type tx_sel;
  logic                remote_fault;
  logic                loop_active;
  logic                next_copper_fault_out;
  logic                next_fibre_fault_out;
  lfp_pkg::lfp_tx_type next_tx_sel;
  logic                next_remote_fault;
  logic                next_loop_active;

  // ==========================================================================
  // next values
  always_comb begin
    next_copper_fault_out = lfp_pkg::LFP_FAULT_RST;
    next_fibre_fault_out  = lfp_pkg::LFP_FAULT_RST;
    next_remote_fault     = lfp_pkg::LFP_FAULT_RST;
    next_tx_sel           = lfp_pkg::LFP_TX_DATA;
    next_loop_active      = loop_wanted(mode_i, loop_mode_i, rx_link_ok_i);
    case (mode_i)
      lfp_pkg::LFP_MODE_FIBRE: begin
        next_fibre_fault_out = !rx_link_ok_i;
        // a far-end fault is kept apart and never forwarded as local loss
        next_remote_fault    = rx_link_ok_i && rx_far_end_fault_i;
        if (peer_fault_i) begin
          next_tx_sel = lfp_pkg::LFP_TX_FEF;
        end else if (next_loop_active) begin
          next_tx_sel = lfp_pkg::LFP_TX_LOOP;
        end
      end
      lfp_pkg::LFP_MODE_COPPER: begin
        next_copper_fault_out = !rx_link_ok_i;
        if (peer_fault_i) begin
          next_tx_sel = lfp_pkg::LFP_TX_QUIET;
        end
      end
      default: begin
        next_tx_sel = lfp_pkg::LFP_TX_DATA;
      end
    endcase
  end

  // ==========================================================================
  // registers; every path above falls back to clear values, so recovery is
  // automatic one clock after the cause ends
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      copper_fault_out <= lfp_pkg::LFP_FAULT_RST;
      fibre_fault_out  <= lfp_pkg::LFP_FAULT_RST;
      tx_sel           <= lfp_pkg::LFP_TX_RST;
      remote_fault     <= lfp_pkg::LFP_FAULT_RST;
      loop_active      <= lfp_pkg::LFP_LOOP_RST;
    end else begin
      copper_fault_out <= next_copper_fault_out;
      fibre_fault_out  <= next_fibre_fault_out;
      tx_sel           <= next_tx_sel;
      remote_fault     <= next_remote_fault;
      loop_active      <= next_loop_active;
    end
  end

  assign copper_fault_out_o = copper_fault_out;
  assign fibre_fault_out_o  = fibre_fault_out;
  assign tx_sel_o           = tx_sel;
  assign remote_fault_o     = remote_fault;
  assign loop_active_o      = loop_active;

  // ==========================================================================
  // checks
  sequence fibre_loss_s;
    (mode_i == lfp_pkg::LFP_MODE_FIBRE) && !rx_link_ok_i;
  endsequence

  sequence copper_peer_s;
    (mode_i == lfp_pkg::LFP_MODE_COPPER) && peer_fault_i;
  endsequence

  fibre_fault_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fibre_loss_s |=> fibre_fault_out_o)
    else $error("fibre fault not raised on fibre link loss");

  far_end_kept_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((mode_i == lfp_pkg::LFP_MODE_FIBRE) && rx_link_ok_i && rx_far_end_fault_i)
      |=> (remote_fault_o && !fibre_fault_out_o))
    else $error("far-end fault mixed with local link loss");

  fef_send_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((mode_i == lfp_pkg::LFP_MODE_FIBRE) && peer_fault_i)
      |=> (tx_sel_o == lfp_pkg::LFP_TX_FEF))
    else $error("far-end fault pattern not sent");

  copper_fault_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((mode_i == lfp_pkg::LFP_MODE_COPPER) && !rx_link_ok_i) |=> copper_fault_out_o)
    else $error("copper fault not raised on link loss");

  idle_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    copper_peer_s |=> (tx_sel_o == lfp_pkg::LFP_TX_QUIET))
    else $error("idle not stopped on peer fault");

  loop_route_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    loop_active_o |-> ($past(mode_i) == lfp_pkg::LFP_MODE_FIBRE))
    else $error("loopback active outside fibre mode");

  fault_split_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(copper_fault_out_o && fibre_fault_out_o))
    else $error("both fault outputs raised together");

  recover_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rx_link_ok_i && !peer_fault_i)[*2] |-> (!copper_fault_out_o && !fibre_fault_out_o &&
      (tx_sel_o != lfp_pkg::LFP_TX_FEF) && (tx_sel_o != lfp_pkg::LFP_TX_QUIET)))
    else $error("fault not cleared after recovery");

  // ==========================================================================
  // recovery, exclusion, loopback and reset checks
  sequence copper_loss_s;
    copper_sel(mode_i) && !rx_link_ok_i;
  endsequence

  sequence fibre_back_s;
    fibre_loss_s ##1 rx_link_ok_i;
  endsequence

  sequence copper_back_s;
    copper_loss_s ##1 rx_link_ok_i;
  endsequence

  sequence peer_drop_s;
    copper_peer_s ##1 !peer_fault_i;
  endsequence

  fibre_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fibre_back_s |-> fibre_fault_out_o ##1 !fibre_fault_out_o)
    else $error("fibre fault held after link return");

  copper_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    copper_back_s |-> copper_fault_out_o ##1 !copper_fault_out_o)
    else $error("copper fault held after link return");

  quiet_release_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    peer_drop_s |-> (tx_sel_o == lfp_pkg::LFP_TX_QUIET) ##1 (tx_sel_o != lfp_pkg::LFP_TX_QUIET))
    else $error("copper transmitter stays quiet after peer fault ends");

  idle_resume_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (copper_sel(mode_i) && !peer_fault_i) |=> (tx_sel_o == lfp_pkg::LFP_TX_DATA))
    else $error("copper idle not sent without peer fault");

  copper_tx_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    copper_sel(mode_i) |=> ((tx_sel_o != lfp_pkg::LFP_TX_FEF) &&
      (tx_sel_o != lfp_pkg::LFP_TX_LOOP)))
    else $error("fibre-only transmit choice in copper mode");

  fibre_tx_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fibre_sel(mode_i) |=> (tx_sel_o != lfp_pkg::LFP_TX_QUIET))
    else $error("fibre transmitter silenced instead of far-end fault");

  fibre_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    copper_sel(mode_i) |=> !fibre_fault_out_o)
    else $error("fibre fault raised in copper mode");

  copper_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fibre_sel(mode_i) |=> !copper_fault_out_o)
    else $error("copper fault raised in fibre mode");

  dead_not_far_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fibre_loss_s |=> !remote_fault_o)
    else $error("dead link reported as far-end fault");

  far_copper_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    copper_sel(mode_i) |=> !remote_fault_o)
    else $error("far-end fault reported in copper mode");

  loop_enter_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (loop_wanted(mode_i, loop_mode_i, rx_link_ok_i) && !peer_fault_i)
      |=> (loop_active_o && (tx_sel_o == lfp_pkg::LFP_TX_LOOP)))
    else $error("loopback not entered");

  // the loop flag stays up under a peer fault; only the transmitter gives way
  peer_over_loop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (loop_wanted(mode_i, loop_mode_i, rx_link_ok_i) && peer_fault_i)
      |=> (loop_active_o && (tx_sel_o == lfp_pkg::LFP_TX_FEF)))
    else $error("peer fault did not take the transmitter from loopback");

  loop_copper_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    copper_sel(mode_i) |=> !loop_active_o)
    else $error("loopback active after copper mode");

  reset_clear_a: assert property (@(posedge mclk_i)
    rst_i |=> ((copper_fault_out_o == lfp_pkg::LFP_FAULT_RST) &&
      (fibre_fault_out_o == lfp_pkg::LFP_FAULT_RST) && (tx_sel_o == lfp_pkg::LFP_TX_RST) &&
      (remote_fault_o == lfp_pkg::LFP_FAULT_RST) && (loop_active_o == lfp_pkg::LFP_LOOP_RST)))
    else $error("outputs not cleared by reset");

endmodule

// *** testbench/lfp_peer_model.sv ***
// peer transceiver model on the converter_link_interface
// assumes its own media link status comes from the bench
`timescale 1ns/10ps
module lfp_peer_model (
  // clock and own media status
  input  wire logic mclk_i,
  input  wire logic link_ok_i,
  // fault toward the device
  output logic      fault_o
);
  // ==========================================================================
  // registered like a real peer, so the fault never moves mid-cycle
  always @(posedge mclk_i) fault_o <= !link_ok_i;
endmodule

// *** testbench/tb_lfp_core.sv ***
// self-checking bench for lfp_core beside a peer transceiver model
// assumes lfp_pkg, lfp_core and lfp_peer_model compiled first
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb_lfp_core;
  // ==========================================================================
  // signals
  logic                  mclk_i      = 1'h0;
  logic                  rst_i       = 1'h1;
  lfp_pkg::lfp_mode_type mode_i      = lfp_pkg::LFP_MODE_COPPER;
  lfp_pkg::lfp_loop_type loop_mode_i = lfp_pkg::LFP_LB_OFF;
  logic                  link        = 1'h1;
  logic                  far         = 1'h0;
  logic                  peer_link   = 1'h1;
  logic                  peer_fault, cf, ff, rf, la, fx, lb;
  lfp_pkg::lfp_tx_type   tx;
  logic [1:0]            t;
  logic [5:0]            exp_q[$];
  logic [5:0]            e, note;
  int                    errors = 0, total_checks = 0, cyc = 0, seed = 66;

  always #20 mclk_i = ~mclk_i;

  lfp_peer_model peer_u (.mclk_i(mclk_i), .link_ok_i(peer_link), .fault_o(peer_fault));
  lfp_core dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode_i), .loop_mode_i(loop_mode_i),
    .rx_link_ok_i(link), .rx_far_end_fault_i(far), .peer_fault_i(peer_fault),
    .copper_fault_out_o(cf), .fibre_fault_out_o(ff), .tx_sel_o(tx),
    .remote_fault_o(rf), .loop_active_o(la));

  // ==========================================================================
  // driver: random levels at the falling edge, expected outputs queued
  always @(negedge mclk_i) begin
    cyc++;
    // rare resets in mid-run check the clear path too
    rst_i = (cyc < 8) || ({$random(seed)} % 60 == 0);
    mode_i = lfp_pkg::lfp_mode_type'($random(seed) & 1);
    loop_mode_i = lfp_pkg::lfp_loop_type'({$random(seed)} % 3);
    link = ({$random(seed)} % 4) != 0;
    far = ($random(seed) & 1) != 0;
    peer_link = ({$random(seed)} % 3) != 0;
    fx = (mode_i == lfp_pkg::LFP_MODE_FIBRE);
    lb = fx && link && (loop_mode_i != lfp_pkg::LFP_LB_OFF);
    t = peer_fault ? (fx ? lfp_pkg::LFP_TX_FEF : lfp_pkg::LFP_TX_QUIET)
                   : (lb ? lfp_pkg::LFP_TX_LOOP : lfp_pkg::LFP_TX_DATA);
    // loop flag ignores the peer fault; only the transmit choice gives way
    e = rst_i ? 6'h00 : {!fx && !link, fx && !link, t, fx && link && far, lb};
    exp_q.push_back(e);
  end

  // ==========================================================================
  // monitor: one result per rising edge against the oldest note
  always @(posedge mclk_i) begin
    #1;
    if (exp_q.size() > 0) begin
      note = exp_q.pop_front();
      `CHK("copper_fault", note[5], cf)
      `CHK("fibre_fault", note[4], ff)
      `CHK("tx_sel", note[3:2], tx)
      `CHK("remote_fault", note[1], rf)
      `CHK("loop_active", note[0], la)
    end
    if (cyc > 2000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (800) @(posedge mclk_i);
    report_and_stop();
  end
endmodule
